// >>> hw/cteu_pkg.sv
// Constants for the CPU trap and exception unit: register map, status word
// layout, handler addresses, cause codes and the trap-class instruction encodings.
// Assumes a 32-bit instruction word and a 32-bit AHB-Lite register port.
package cteu_pkg;

    // Register byte offsets on the AHB-Lite port.
    localparam logic [4:0] OFS_PSW = 5'h00;
    localparam logic [4:0] OFS_EXC_RET_PC = 5'h04;
    localparam logic [4:0] OFS_EXC_RET_STATUS = 5'h08;
    localparam logic [4:0] OFS_CAUSE = 5'h0C;
    localparam logic [4:0] OFS_DBG_RET_PC = 5'h10;
    localparam logic [4:0] OFS_DBG_RET_STATUS = 5'h14;
    localparam logic [4:0] OFS_IRQ_STATUS = 5'h18;
    localparam logic [4:0] OFS_IRQ_MASK = 5'h1C;

    // Status word field positions and value after reset.
    localparam int PSW_ID_BIT = 5;
    localparam int PSW_EP_BIT = 6;
    localparam int PSW_NP_BIT = 7;
    localparam logic [31:0] PSW_RESET = 32'h0000_0020;

    // Handler addresses.
    localparam logic [31:0] HANDLER_TRAP_LOW = 32'h0000_0040;
    localparam logic [31:0] HANDLER_TRAP_HIGH = 32'h0000_0050;
    localparam logic [31:0] HANDLER_DEBUG = 32'h0000_0060;
    localparam logic [4:0] TRAP_VECTOR_SPLIT = 5'h10;

    // Cause code written for a trap: base ORed with the vector.
    localparam logic [15:0] TRAP_CODE_BASE = 16'h0040;

    // Instruction fields and encodings of the trap class.
    localparam logic [5:0] OPC_EXT = 6'h3F;
    localparam logic [3:0] SUB_TRAP = 4'h0;
    localparam logic [3:0] SUB_EXCEPTION_RETURN_INSTR = 4'h1;
    localparam logic [3:0] SUB_DEBUG_RETURN_INSTR = 4'h2;
    localparam logic [3:0] SUB_DEBUG_TRAP_INSTR = 4'h3;
    localparam logic [3:0] SUB_ILLEGAL_LO = 4'h7;

    // Interrupt status bit positions and register reset values.
    localparam int EV_TRAP = 0;
    localparam int EV_ILLEGAL = 1;
    localparam int EV_DEBUG_TRAP_INSTR = 2;
    localparam int EV_RETURN = 3;
    localparam int EV_EXCEPTION_RETURN_INSTR_IGNORED = 4;
    localparam int EV_COUNT = 5;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;

endpackage

// >>> hw/cteu_dec_if.sv
// Interface between the exception core and its instruction classifier.
// Assumes the classifier is purely combinational on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface cteu_dec_if;
    logic [31:0] instr;
    logic is_trap;
    logic is_exception_return_instr;
    logic is_debug_return_instr;
    logic is_debug_trap_instr;
    logic is_illegal;
    logic [4:0] vector;

    modport dec (input instr, output is_trap, is_exception_return_instr, is_debug_return_instr, is_debug_trap_instr, is_illegal, vector);
    modport core (output instr, input is_trap, is_exception_return_instr, is_debug_return_instr, is_debug_trap_instr, is_illegal, vector);
endinterface
`default_nettype wire

// >>> hw/cteu_decoder.sv
// Classifier for the trap-class instructions of the executing instruction word.
// Assumes the core drives the word from its execute stage; output is combinational.
`timescale 1ns/100ps
`default_nettype none
module cteu_decoder
    import cteu_pkg::*;
(
    cteu_dec_if.dec dbus // Instruction in, class flags out.
);
    logic ext_space;
    logic [3:0] sub;

    // Extended opcode space with bit 16 clear holds every trap-class instruction.
    always_comb begin
        ext_space = (dbus.instr[10:5] == OPC_EXT) && (dbus.instr[16] == 1'b0);
        sub = dbus.instr[26:23];
    end

    // Sub-opcodes 7 and above are reserved and so illegal.
    always_comb begin
        dbus.is_illegal = ext_space && (sub >= SUB_ILLEGAL_LO);
        dbus.is_trap = ext_space && (sub == SUB_TRAP);
        dbus.is_exception_return_instr = ext_space && (sub == SUB_EXCEPTION_RETURN_INSTR);
        dbus.is_debug_return_instr = ext_space && (sub == SUB_DEBUG_RETURN_INSTR);
        dbus.is_debug_trap_instr = ext_space && (sub == SUB_DEBUG_TRAP_INSTR);
        dbus.vector = dbus.instr[4:0];
    end
endmodule
`default_nettype wire

// >>> hw/cteu_top.sv
// CPU trap and exception unit: takes traps, illegal opcodes and debug traps,
// saves and restores PC and status word, and redirects the fetch unit.
// Assumes the pipeline presents one executing instruction per valid cycle and
// refetches from PC_TARGET_O when PC_LOAD_O pulses; registers sit on AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
module cteu_top
    import cteu_pkg::*;
(
    input wire logic CLK_I, // System clock, 125 MHz.
    input wire logic NRST_I, // Synchronous reset, active low.
    input wire logic HSEL_I, // AHB slave select.
    input wire logic [31:0] HADDR_I, // AHB address.
    input wire logic [1:0] HTRANS_I, // AHB transfer type.
    input wire logic HWRITE_I, // AHB write when high.
    input wire logic [2:0] HSIZE_I, // AHB size, word only.
    input wire logic [31:0] HWDATA_I, // AHB write data.
    input wire logic HREADY_I, // AHB bus ready.
    output logic [31:0] HRDATA_O, // AHB read data.
    output logic HREADYOUT_O, // AHB slave ready.
    output logic HRESP_O, // AHB response, always OKAY.
    input wire logic INSTR_VALID_I, // Executing instruction is valid.
    input wire logic [31:0] INSTR_I, // Executing instruction word.
    input wire logic [31:0] RET_PC_I, // PC to return to after it.
    output logic PC_LOAD_O, // One-cycle redirect pulse.
    output logic [31:0] PC_TARGET_O, // Redirect address.
    output logic FLUSH_O, // Discard younger instructions.
    output logic [31:0] PSW_O, // Current status word.
    output logic IRQ_O // Unmasked event pending.
);
    cteu_dec_if dec_bus();
    cteu_decoder u_dec (
        .dbus(dec_bus.dec)
    );

    logic [31:0] psw_reg, psw_next;
    logic [31:0] exc_return_pc_reg, exc_return_status_reg;
    logic [31:0] exception_cause_reg;
    logic [31:0] debug_return_pc_reg, debug_return_status_reg;
    logic [EV_COUNT-1:0] irq_status_reg, irq_status_next, irq_mask_reg, events;
    logic pc_load_reg, flush_reg, irq_reg;
    logic [31:0] pc_target_reg, hrdata_reg, rd_val;
    logic hreadyout_reg;
    logic wr_pend_reg, rd_pend_reg;
    logic [4:0] addr_reg;
    logic accept, take_trap, take_ilg, take_dbt, take_exception_return_instr, take_debug_return_instr, exception_return_instr_skip;
    logic redirect, ahb_go, sw_wr;
    logic [31:0] target;

    assign dec_bus.instr = INSTR_I;

    // An instruction arriving while the redirect pulse stands is younger than
    // the excepting one and is dropped, so the handler runs next.
    always_comb begin
        accept = INSTR_VALID_I && !pc_load_reg;
        take_trap = accept && dec_bus.is_trap;
        take_ilg = accept && dec_bus.is_illegal;
        take_dbt = accept && dec_bus.is_debug_trap_instr;
        take_exception_return_instr = accept && dec_bus.is_exception_return_instr && psw_reg[PSW_EP_BIT];
        exception_return_instr_skip = accept && dec_bus.is_exception_return_instr && !psw_reg[PSW_EP_BIT];
        take_debug_return_instr = accept && dec_bus.is_debug_return_instr;
        redirect = take_trap || take_ilg || take_dbt || take_exception_return_instr || take_debug_return_instr;
    end

    // Redirect address: the trap vector picks one of two handlers.
    always_comb begin
        target = HANDLER_DEBUG;
        if (take_trap) begin
            target = (dec_bus.vector < TRAP_VECTOR_SPLIT) ? HANDLER_TRAP_LOW
                                                          : HANDLER_TRAP_HIGH;
        end else if (take_exception_return_instr) begin
            target = exc_return_pc_reg;
        end else if (take_debug_return_instr) begin
            target = debug_return_pc_reg;
        end
    end

    // AHB address phase accepted this cycle; writes land in the data phase.
    always_comb begin
        ahb_go = HSEL_I && HTRANS_I[1] && HREADY_I;
        sw_wr = wr_pend_reg;
    end

    // Status word next value. Hardware events beat a software write landing
    // in the same cycle, since losing an exception entry is unrecoverable.
    always_comb begin
        psw_next = psw_reg;
        if (take_trap) begin
            psw_next[PSW_EP_BIT] = 1'b1;
            psw_next[PSW_ID_BIT] = 1'b1;
        end else if (take_ilg || take_dbt) begin
            psw_next[PSW_NP_BIT] = 1'b1;
            psw_next[PSW_EP_BIT] = 1'b1;
            psw_next[PSW_ID_BIT] = 1'b1;
        end else if (take_exception_return_instr) begin
            psw_next = exc_return_status_reg;
        end else if (take_debug_return_instr) begin
            psw_next = debug_return_status_reg;
        end else if (sw_wr && addr_reg == OFS_PSW) begin
            psw_next = HWDATA_I;
        end
    end

    // Status word register.
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            psw_reg <= PSW_RESET;
        end else begin
            psw_reg <= psw_next;
        end
    end

    // Exception return pair, saved on a trap and writable by software so a
    // nested handler can spill and restore it.
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            exc_return_pc_reg <= REG_RESET;
            exc_return_status_reg <= REG_RESET;
        end else if (take_trap) begin
            exc_return_pc_reg <= RET_PC_I;
            exc_return_status_reg <= psw_reg;
        end else if (sw_wr) begin
            if (addr_reg == OFS_EXC_RET_PC) begin
                exc_return_pc_reg <= HWDATA_I;
            end
            if (addr_reg == OFS_EXC_RET_STATUS) begin
                exc_return_status_reg <= HWDATA_I;
            end
        end
    end

    // Cause register; only the low half is defined, the upper half reads zero.
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            exception_cause_reg <= REG_RESET;
        end else if (take_trap) begin
            exception_cause_reg <= {16'h0000, TRAP_CODE_BASE | {11'h000, dec_bus.vector}};
        end else if (sw_wr && addr_reg == OFS_CAUSE) begin
            exception_cause_reg <= {16'h0000, HWDATA_I[15:0]};
        end
    end

    // Debug return pair, shared by illegal-opcode traps and debug traps.
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            debug_return_pc_reg <= REG_RESET;
            debug_return_status_reg <= REG_RESET;
        end else if (take_ilg || take_dbt) begin
            debug_return_pc_reg <= RET_PC_I;
            debug_return_status_reg <= psw_reg;
        end else if (sw_wr) begin
            if (addr_reg == OFS_DBG_RET_PC) begin
                debug_return_pc_reg <= HWDATA_I;
            end
            if (addr_reg == OFS_DBG_RET_STATUS) begin
                debug_return_status_reg <= HWDATA_I;
            end
        end
    end

    // Redirect pulse to fetch; flush goes with it so nothing younger retires.
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            pc_load_reg <= 1'b0;
            flush_reg <= 1'b0;
            pc_target_reg <= REG_RESET;
        end else begin
            pc_load_reg <= redirect;
            flush_reg <= redirect;
            if (redirect) begin
                pc_target_reg <= target;
            end
        end
    end

    // Event flags; a set in the same cycle as a write-one clear wins.
    always_comb begin
        events = '0;
        events[EV_TRAP] = take_trap;
        events[EV_ILLEGAL] = take_ilg;
        events[EV_DEBUG_TRAP_INSTR] = take_dbt;
        events[EV_RETURN] = take_exception_return_instr || take_debug_return_instr;
        events[EV_EXCEPTION_RETURN_INSTR_IGNORED] = exception_return_instr_skip;
        irq_status_next = irq_status_reg;
        if (sw_wr && addr_reg == OFS_IRQ_STATUS) begin
            irq_status_next = irq_status_reg & ~HWDATA_I[EV_COUNT-1:0];
        end
        irq_status_next = irq_status_next | events;
    end

    // Interrupt status, mask and the level output built from the next status and the current mask.
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            irq_status_reg <= '0;
            irq_mask_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            irq_status_reg <= irq_status_next;
            if (sw_wr && addr_reg == OFS_IRQ_MASK) begin
                irq_mask_reg <= HWDATA_I[EV_COUNT-1:0];
            end
            irq_reg <= |(irq_status_next & irq_mask_reg);
        end
    end

    // Read multiplexer; unmapped offsets read zero.
    always_comb begin
        case (addr_reg)
            OFS_PSW: rd_val = psw_reg;
            OFS_EXC_RET_PC: rd_val = exc_return_pc_reg;
            OFS_EXC_RET_STATUS: rd_val = exc_return_status_reg;
            OFS_CAUSE: rd_val = exception_cause_reg;
            OFS_DBG_RET_PC: rd_val = debug_return_pc_reg;
            OFS_DBG_RET_STATUS: rd_val = debug_return_status_reg;
            OFS_IRQ_STATUS: rd_val = {27'h0000000, irq_status_reg};
            OFS_IRQ_MASK: rd_val = {27'h0000000, irq_mask_reg};
            default: rd_val = REG_RESET;
        endcase
    end

    // AHB-Lite slave. Reads take one wait state so a write in the previous
    // data phase has landed before the register is sampled.
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg <= 5'h00;
            hreadyout_reg <= 1'b1;
            hrdata_reg <= REG_RESET;
        end else begin
            wr_pend_reg <= ahb_go && HWRITE_I;
            rd_pend_reg <= ahb_go && !HWRITE_I;
            if (ahb_go) begin
                addr_reg <= (HADDR_I[31:5] == 27'h0000000) ? HADDR_I[4:0] : 5'h1F;
            end
            if (ahb_go && !HWRITE_I) begin
                hreadyout_reg <= 1'b0;
            end else if (rd_pend_reg) begin
                hreadyout_reg <= 1'b1;
                hrdata_reg <= rd_val;
            end
        end
    end

    assign HRDATA_O = hrdata_reg;
    assign HREADYOUT_O = hreadyout_reg;
    assign HRESP_O = 1'b0;
    assign PC_LOAD_O = pc_load_reg;
    assign FLUSH_O = flush_reg;
    assign PC_TARGET_O = pc_target_reg;
    assign PSW_O = psw_reg;
    assign IRQ_O = irq_reg;

    // Checks on the exception entry and return sequences.
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);

    sequence s_trap_lo;
        accept && dec_bus.is_trap && (dec_bus.vector < TRAP_VECTOR_SPLIT);
    endsequence
    sequence s_trap_hi;
        accept && dec_bus.is_trap && (dec_bus.vector >= TRAP_VECTOR_SPLIT);
    endsequence
    sequence s_debug_entry;
        accept && (dec_bus.is_debug_trap_instr || dec_bus.is_illegal);
    endsequence

    property p_trap_always;
        INSTR_VALID_I && !pc_load_reg && dec_bus.is_trap && psw_reg[PSW_ID_BIT]
            |=> PC_LOAD_O && FLUSH_O;
    endproperty
    a_trap_always: assert property (p_trap_always) else $error("Masked trap not taken.");

    property p_trap_save;
        take_trap |=> exc_return_pc_reg == $past(RET_PC_I)
            && exc_return_status_reg == $past(psw_reg);
    endproperty
    a_trap_save: assert property (p_trap_save) else $error("Trap save wrong.");

    property p_trap_cause;
        take_trap |=> exception_cause_reg[15:0] == (TRAP_CODE_BASE | {11'h000, $past(INSTR_I[4:0])})
            && exception_cause_reg[31:16] == 16'h0000;
    endproperty
    a_trap_cause: assert property (p_trap_cause) else $error("Trap cause code wrong.");

    property p_trap_flags;
        take_trap |=> PSW_O[PSW_EP_BIT] && PSW_O[PSW_ID_BIT];
    endproperty
    a_trap_flags: assert property (p_trap_flags) else $error("Trap flags not set.");

    property p_trap_vector;
        (s_trap_lo |=> PC_TARGET_O == HANDLER_TRAP_LOW)
            and (s_trap_hi |=> PC_TARGET_O == HANDLER_TRAP_HIGH);
    endproperty
    a_trap_vector: assert property (p_trap_vector) else $error("Trap handler wrong.");

    property p_exception_return_instr;
        take_exception_return_instr |=> PC_LOAD_O && PC_TARGET_O == $past(exc_return_pc_reg)
            && PSW_O == $past(exc_return_status_reg);
    endproperty
    a_exception_return_instr: assert property (p_exception_return_instr) else $error("Exception return wrong.");

    property p_ep_set;
        (take_trap || take_ilg || take_dbt) |=> PSW_O[6];
    endproperty
    a_ep_set: assert property (p_ep_set) else $error("Exception flag not at bit 6.");

    property p_illegal;
        INSTR_VALID_I && !pc_load_reg && INSTR_I[10:5] == 6'h3F && INSTR_I[26:23] >= 4'h7
            && !INSTR_I[16] |=> PC_LOAD_O && PC_TARGET_O == 32'h0000_0060;
    endproperty
    a_illegal: assert property (p_illegal) else $error("Illegal opcode not trapped.");

    property p_debug_entry;
        s_debug_entry |=> PC_TARGET_O == HANDLER_DEBUG && PSW_O[PSW_NP_BIT]
            && PSW_O[PSW_EP_BIT] && PSW_O[PSW_ID_BIT]
            && debug_return_pc_reg == $past(RET_PC_I)
            && debug_return_status_reg == $past(psw_reg);
    endproperty
    a_debug_entry: assert property (p_debug_entry) else $error("Debug entry wrong.");

    property p_debug_return_instr;
        take_debug_return_instr |=> PC_LOAD_O && PC_TARGET_O == $past(debug_return_pc_reg)
            && PSW_O == $past(debug_return_status_reg);
    endproperty
    a_debug_return_instr: assert property (p_debug_return_instr) else $error("Debug return wrong.");

    // A younger instruction during the redirect cycle must leave state alone;
    // a software write landing in that cycle is the only other way in.
    property p_no_double;
        PC_LOAD_O && !wr_pend_reg |=> !PC_LOAD_O && $stable(PSW_O)
            && $stable(exc_return_pc_reg) && $stable(debug_return_pc_reg)
            && $stable(exception_cause_reg);
    endproperty
    a_no_double: assert property (p_no_double) else $error("Younger instruction acted on.");

endmodule
`default_nettype wire

// >>> test/cteu_pipe_model.sv
// Pipeline model that presents executing instructions to the exception unit.
// Assumes the bench calls its tasks just after a rising edge of the system clock.
`timescale 1ns/100ps
`default_nettype none
module cteu_pipe_model (
    input wire logic clk_i, // System clock.
    output logic valid_o, // Instruction valid.
    output logic [31:0] instr_o, // Executing instruction word.
    output logic [31:0] ret_pc_o // Return PC of that instruction.
);
    // Nothing is executing until the bench asks for it.
    initial begin
        valid_o = 1'b0;
        instr_o = 32'h0000_0000;
        ret_pc_o = 32'h0000_0000;
    end
    // One instruction is taken at the next edge; a younger one follows at once, as a real
    // pipeline would, so a redirect that fails to discard it is seen.
    task automatic issue(input logic [31:0] w, input logic [31:0] pc, input logic [31:0] y);
        valid_o <= 1'b1;
        instr_o <= w;
        ret_pc_o <= pc;
        @(posedge clk_i);
        instr_o <= y;
        ret_pc_o <= pc + 32'h0000_0004;
    endtask
    // Released lines show inverted stale values, so nothing relies on leftovers.
    task automatic rest();
        valid_o <= 1'b0;
        instr_o <= ~instr_o;
        ret_pc_o <= ~ret_pc_o;
    endtask
endmodule
`default_nettype wire

// >>> test/test_cteu_top.sv
// Self-checking bench for the trap and exception unit.
// Assumes the pipeline model beside it and a single AHB-Lite master in the bench.
`timescale 1ns/100ps
`default_nettype none
module test_cteu_top
    import cteu_pkg::*;
;
    localparam int TIMEOUT_CYCLES = 20000;
    logic clk, nrst, hsel, hwrite, valid, pcl, flush, irq, hrdy, hresp;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, instr, retpc, pct, program_status_word;
    int err_total = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [31:0] noop;
    logic [31:0] young;

    cteu_top i_cteu_top (.CLK_I(clk), .NRST_I(nrst), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
        .HREADY_I(hrdy), .HRDATA_O(hrdata), .HREADYOUT_O(hrdy), .HRESP_O(hresp),
        .INSTR_VALID_I(valid), .INSTR_I(instr), .RET_PC_I(retpc), .PC_LOAD_O(pcl),
        .PC_TARGET_O(pct), .FLUSH_O(flush), .PSW_O(program_status_word), .IRQ_O(irq));
    cteu_pipe_model i_cteu_pipe_model (.clk_i(clk), .valid_o(valid), .instr_o(instr),
        .ret_pc_o(retpc));

    // Clock at 125 MHz.
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // A hang is cut short here and reported as a mismatch.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == TIMEOUT_CYCLES) begin
            err_total++;
            test_done();
        end
    end

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Trap-class instruction word: sub-opcode, vector and bit 16.
    function automatic logic [31:0] mk(input logic [3:0] s, input logic [4:0] v, input logic b);
        return {5'h00, s, 6'h00, b, 5'h00, OPC_EXT, v};
    endfunction

    // One AHB-Lite single word transfer; the wait for hready covers the read wait state.
    task automatic ahb(input logic w, input logic [4:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        htrans <= 2'b10;
        haddr <= {27'h0, a};
        hwrite <= w;
        do @(posedge clk); while (hrdy !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk); while (hrdy !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        ahb(1'b1, a, d, dummy);
    endtask

    task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] d;
        ahb(1'b0, a, 32'h0000_0000, d);
        chk(d, exp);
    endtask

    // Executes one instruction, checks the answer in the redirect cycle, then checks that the
    // younger instruction held during that cycle left no trace.
    task automatic exec(input logic [31:0] w, input logic [31:0] pc, input logic [31:0] y,
                        input logic ld, input logic [31:0] tgt, input logic [31:0] ps);
        i_cteu_pipe_model.issue(w, pc, y);
        #1;
        chk(pcl, ld);
        chk(flush, ld);
        if (ld) begin
            chk(pct, tgt);
        end
        chk(program_status_word, ps);
        @(posedge clk);
        i_cteu_pipe_model.rest();
        #1;
        chk(pcl, 1'b0);
        chk(program_status_word, ps);
    endtask

    task automatic t_reset();
        chk(program_status_word, PSW_RESET);
        chk(irq, 1'b0);
        chk(pct, 32'h0000_0000);
        chk(hresp, 1'b0);
        chk(flush, 1'b0);
        for (int i = 1; i < 8; i++) begin
            rdchk(5'(i * 4), REG_RESET);
        end
        rdchk(OFS_PSW, PSW_RESET);
        $display("test reset done");
    endtask

    task automatic t_trap();
        logic [4:0] vecs [4] = '{5'h00, 5'h0F, 5'h10, 5'h1F};
        logic [31:0] ps0;
        logic [31:0] pc;
        for (int i = 0; i < 4; i++) begin
            ps0 = vecs[i][0] ? 32'h0000_0020 : 32'h0000_0000;
            pc = 32'h0000_1000 + {27'h0, vecs[i]};
            wr(OFS_PSW, ps0);
            exec(mk(SUB_TRAP, vecs[i], 1'b0), pc, young, 1'b1, vecs[i] < TRAP_VECTOR_SPLIT ?
                 HANDLER_TRAP_LOW : HANDLER_TRAP_HIGH, ps0 | 32'h0000_0060);
            rdchk(OFS_EXC_RET_PC, pc);
            rdchk(OFS_EXC_RET_STATUS, ps0);
            rdchk(OFS_CAUSE, {16'h0, TRAP_CODE_BASE | {11'h0, vecs[i]}});
            rdchk(OFS_DBG_RET_PC, REG_RESET);
            exec(mk(SUB_EXCEPTION_RETURN_INSTR, 5'h0, 1'b0), 32'h0, young, 1'b1, pc, ps0);
        end
        exec(mk(SUB_EXCEPTION_RETURN_INSTR, 5'h0, 1'b0), 32'h0, noop, 1'b0, 32'h0, ps0);
        $display("test trap done");
    endtask

    task automatic t_illegal();
        logic [31:0] pc;
        for (int s = 7; s < 16; s++) begin
            pc = 32'h0000_2000 + 32'(s * 4);
            wr(OFS_PSW, 32'h0000_0000);
            exec(mk(4'(s), 5'h0, 1'b0), pc, young, 1'b1, HANDLER_DEBUG, 32'h0000_00E0);
            rdchk(OFS_DBG_RET_PC, pc);
            rdchk(OFS_DBG_RET_STATUS, 32'h0000_0000);
            exec(mk(SUB_DEBUG_RETURN_INSTR, 5'h0, 1'b0), 32'h0, young, 1'b1, pc, 32'h0);
        end
        exec(mk(4'h7, 5'h0, 1'b1), 32'h0, noop, 1'b0, 32'h0, 32'h0);
        exec(mk(4'h6, 5'h0, 1'b0), 32'h0, noop, 1'b0, 32'h0, 32'h0);
        exec(mk(4'h7, 5'h0, 1'b0) ^ 32'h0000_0020, 32'h0, noop, 1'b0, 32'h0, 32'h0);
        $display("test illegal done");
    endtask

    task automatic t_debug_trap_instr();
        wr(OFS_PSW, 32'h0000_0020);
        exec(mk(SUB_DEBUG_TRAP_INSTR, 5'h0, 1'b0), 32'h0000_3000, young, 1'b1, HANDLER_DEBUG,
             32'h0000_00E0);
        rdchk(OFS_DBG_RET_PC, 32'h0000_3000);
        rdchk(OFS_DBG_RET_STATUS, 32'h0000_0020);
        exec(mk(SUB_DEBUG_RETURN_INSTR, 5'h0, 1'b0), 32'h0, young, 1'b1, 32'h0000_3000, 32'h0000_0020);
        $display("test debug trap done");
    endtask

    // Every event has fired by now; mask, clear and a masked event follow.
    task automatic t_irq();
        rdchk(OFS_IRQ_STATUS, 32'h0000_001F);
        chk(irq, 1'b0);
        wr(OFS_IRQ_MASK, 32'h0000_001F);
        rdchk(OFS_IRQ_MASK, 32'h0000_001F);
        chk(irq, 1'b1);
        wr(OFS_IRQ_STATUS, 32'h0000_001F);
        rdchk(OFS_IRQ_STATUS, 32'h0000_0000);
        chk(irq, 1'b0);
        wr(OFS_IRQ_MASK, 32'h0000_001E);
        exec(mk(SUB_TRAP, 5'h02, 1'b0), 32'h0, young, 1'b1, HANDLER_TRAP_LOW, 32'h0000_0060);
        rdchk(OFS_IRQ_STATUS, 32'h0000_0001);
        chk(irq, 1'b0);
        wr(OFS_IRQ_MASK, 32'h0000_0001);
        rdchk(OFS_CAUSE, 32'h0000_0042);
        chk(irq, 1'b1);
        $display("test interrupt done");
    endtask

    // Inputs start quiet and reset is held for six cycles.
    initial begin
        noop = mk(4'h4, 5'h0, 1'b0);
        young = mk(SUB_DEBUG_TRAP_INSTR, 5'h0, 1'b0);
        nrst = 1'b0;
        hsel = 1'b1;
        htrans = 2'b00;
        haddr = 32'h0000_0000;
        hwrite = 1'b0;
        hwdata = 32'h0000_0000;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        #1;
        t_reset();
        wr(5'h00, 32'h0000_0020);
        haddr <= 32'h0000_0020;
        t_trap();
        t_illegal();
        t_debug_trap_instr();
        t_irq();
        test_done();
    end
endmodule
`default_nettype wire
